// ---- core/pilc_pkg.sv ----
// constants, types and state layout of the prioritized interrupt latch controller
package pilc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] PILC_IDX_EXT_ENABLE = 8'h2c;
  localparam logic [7:0] PILC_IDX_EXT_LATCH  = 8'h2e;
  localparam logic [7:0] PILC_IDX_LOW_ENABLE = 8'h3a;
  localparam logic [7:0] PILC_IDX_HIGH_ENABLE = 8'h3b;
  localparam logic [7:0] PILC_IDX_LOW_LATCH  = 8'h3c;
  localparam logic [7:0] PILC_IDX_HIGH_LATCH = 8'h3d;

  // field positions
  localparam int         PILC_MASTER_BIT     = 0;
  localparam int         PILC_FIRST_LATCH    = 2;
  localparam int         PILC_FIRST_MASKABLE = 4;
  localparam int         PILC_LAST_SOURCE    = 23;
  localparam logic [4:0] PILC_SRC_SWI        = 5'h00;
  localparam logic [4:0] PILC_SRC_UNDEF      = 5'h01;
  localparam logic [4:0] PILC_SRC_ATRAP      = 5'h02;
  localparam logic [4:0] PILC_SRC_WDT        = 5'h03;
  localparam logic [4:0] PILC_SRC_PIN0       = 5'h04;
  localparam logic [4:0] PILC_SRC_UPPER      = 5'h10;

  // vector addresses
  localparam logic [15:0] PILC_VEC_RESET     = 16'hfffe;
  localparam logic [15:0] PILC_VEC_TRAP      = 16'hfffc;
  localparam logic [15:0] PILC_VEC_LOW_BASE  = 16'hfffe;
  localparam logic [15:0] PILC_VEC_HIGH_BASE = 16'hffde;

  // acceptance sequence length
  localparam int         PILC_ACCEPT_MCYC    = 8;
  localparam int         PILC_CLK_PER_MCYC   = 1;
  localparam logic [3:0] PILC_ACCEPT_LOAD    = 4'(PILC_ACCEPT_MCYC * PILC_CLK_PER_MCYC - 1);

  // bus answers
  localparam logic [1:0] PILC_RESP_OKAY      = 2'h0;
  localparam logic [1:0] PILC_RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    PILC_IDLE = 2'h0,
    PILC_SEQ  = 2'h1,
    PILC_DONE = 2'h3
  } pilc_state_t;

  typedef struct packed {
    pilc_state_t state;
    logic [3:0]  cnt;
    logic [23:0] lat;
    logic [23:0] en;
    logic        stacked_master;
    logic        req;
    logic        nmi;
    logic [4:0]  sel;
    logic [15:0] vec;
    logic        vload;
    logic        awready;
    logic        wready;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  aw_idx;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pilc_regs_t;

  // value after reset: bus ready lines up, everything else clear
  localparam pilc_regs_t PILC_RST = '{
    state: PILC_IDLE, awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

  function automatic logic [15:0] pilc_vector(input logic [4:0] n);
    if (n < PILC_SRC_ATRAP) begin
      return PILC_VEC_TRAP;
    end else if (n < PILC_SRC_UPPER) begin
      return PILC_VEC_LOW_BASE - {10'h000, n, 1'b0};
    end
    return PILC_VEC_HIGH_BASE - {10'h000, n, 1'b0};
  endfunction

endpackage

// ---- core/pilc_top.sv ----
// prioritized interrupt latch controller with axi4-lite register access
//
// Functional notes
// - twenty-four sources besides reset; four internal ones non-maskable, rest maskable.
// - simultaneous requests resolved by fixed hardware priority; non-maskables ranked among themselves in fixed order.
// - each source has own vector except the two traps, which share FFFC; reset FFFE, last FFB0.
// - request event sets its latch; CPU is signalled when source enabled.
// - accepted source's latch clears to zero right at acceptance.
// - reset clears every request latch.
// - software and undefined-opcode traps have no latch; others exactly one.
// - software write may clear a latch but never set it.
// - request latches are readable to monitor pending requests.
// - non-maskable requests ignore master and per-source enables.
// - enable registers readable and writable by any instruction; low enable register bits 1 to 3 stay zero.
// - master enable zero blocks every maskable request.
// - maskable accepted only with master enable, own enable and latch set.
// - acceptance stacks current master enable, then clears it.
// - either return instruction reloads master enable from stacked value.
// - master enable is bit 0 of low enable register; enable-all sets, disable-all clears.
// - reset clears master enable.
// - pin zero needs master enable, its enable bit four and pin enable.
// - latch registers at indices 2E, 3C and 3D.
// - enable registers at indices 2C, 3A and 3B.
// - reset clears all per-source enable flags.
// - acceptance sequence takes eight machine cycles.
`timescale 1ns/100ps

module pilc_top
  import pilc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt sources
  input  wire logic [23:2] request_event,
  input  wire logic        software_trap,
  input  wire logic        undefined_opcode_trap,
  input  wire logic        pin_zero_enable,
  // cpu core side
  input  wire logic        cpu_accept,
  input  wire logic        maskable_return,
  input  wire logic        nonmaskable_return,
  input  wire logic        return_master_enable,
  input  wire logic        enable_all_instruction,
  input  wire logic        disable_all_instruction,
  output logic             int_request,
  output logic             int_nmi,
  output logic [4:0]       int_source,
  output logic [15:0]      int_vector,
  output logic             vector_load,
  output logic             stacked_master_enable,
  output logic             master_enable_flag
);

  pilc_regs_t  s;
  pilc_regs_t  next_s;
  logic [23:0] lat_next;
  logic [23:0] bus_clr;
  logic [23:0] acc_clr;
  logic        accept;
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  rd_idx;
  logic [7:0]  wr_bits;

  assign accept  = cpu_accept && s.req;
  assign wr_fire = s.aw_have && s.w_have && !s.bvalid;
  assign rd_fire = s_axi_arvalid && s.arready;
  assign rd_idx  = s_axi_araddr[9:2];
  assign wr_bits = s.wlane0 ? s.wdata : 8'hff;

  // a zero written into a latch bit clears it; ones do nothing
  always_comb begin
    bus_clr = '0;
    if (wr_fire) begin
      case (s.aw_idx)
        PILC_IDX_LOW_LATCH:  bus_clr[7:0]   = ~wr_bits;
        PILC_IDX_HIGH_LATCH: bus_clr[15:8]  = ~wr_bits;
        PILC_IDX_EXT_LATCH:  bus_clr[23:16] = ~wr_bits;
        default:             bus_clr        = '0;
      endcase
    end
    acc_clr = '0;
    if (accept && s.sel >= PILC_SRC_ATRAP) begin
      acc_clr[s.sel] = 1'b1;
    end
  end

  // no latch behind the two trap sources
  assign lat_next[1:0] = 2'h0;

  genvar gi;
  generate
    for (gi = PILC_FIRST_LATCH; gi <= PILC_LAST_SOURCE; gi++) begin : g_latch
      // set wins over any clear in the same cycle
      assign lat_next[gi] = request_event[gi] ||
                            (s.lat[gi] && !bus_clr[gi] && !acc_clr[gi]);
    end
  endgenerate

  always_comb begin
    logic        master_now;
    logic        found;
    logic        nmi;
    logic [4:0]  pick;
    logic [23:0] en_w;
    master_now = s.en[PILC_MASTER_BIT];
    found  = 1'b0;
    nmi    = 1'b0;
    pick   = '0;
    en_w   = s.en;
    next_s = s;

    // fixed priority, lowest maskable number wins
    for (int n = PILC_LAST_SOURCE; n >= PILC_FIRST_MASKABLE; n--) begin
      if (s.lat[n] && master_now && s.en[n] &&
          (n != PILC_FIRST_MASKABLE || pin_zero_enable)) begin
        found = 1'b1;
        pick  = 5'(n);
      end
    end
    // non-maskables override every enable, taken in a plain fixed order
    if (s.lat[PILC_SRC_WDT] || s.lat[PILC_SRC_ATRAP] ||
        undefined_opcode_trap || software_trap) begin
      found = 1'b1;
      nmi   = 1'b1;
      if (software_trap) begin
        pick = PILC_SRC_SWI;
      end else if (undefined_opcode_trap) begin
        pick = PILC_SRC_UNDEF;
      end else if (s.lat[PILC_SRC_ATRAP]) begin
        pick = PILC_SRC_ATRAP;
      end else begin
        pick = PILC_SRC_WDT;
      end
    end

    // presentation to the core, held off during a sequence
    next_s.req = found && s.state == PILC_IDLE && !accept;
    if (s.state == PILC_IDLE && !accept) begin
      next_s.nmi = nmi;
      next_s.sel = pick;
      next_s.vec = pilc_vector(pick);
    end

    next_s.lat = lat_next;

    // enable register writes
    if (wr_fire && s.wlane0) begin
      case (s.aw_idx)
        PILC_IDX_LOW_ENABLE:  en_w[7:0]   = s.wdata;
        PILC_IDX_HIGH_ENABLE: en_w[15:8]  = s.wdata;
        PILC_IDX_EXT_ENABLE:  en_w[23:16] = s.wdata;
        default:              en_w        = s.en;
      endcase
    end
    en_w[3:1] = 3'h0;
    if (enable_all_instruction) begin
      en_w[PILC_MASTER_BIT] = 1'b1;
    end else if (disable_all_instruction) begin
      en_w[PILC_MASTER_BIT] = 1'b0;
    end
    if (maskable_return || nonmaskable_return) begin
      en_w[PILC_MASTER_BIT] = return_master_enable;
    end
    // acceptance outranks a return or enable-all in the same cycle
    if (accept) begin
      next_s.stacked_master = master_now;
      en_w[PILC_MASTER_BIT] = 1'b0;
    end
    next_s.en = en_w;

    // acceptance sequence
    next_s.vload = 1'b0;
    case (s.state)
      PILC_IDLE: begin
        if (accept) begin
          next_s.state = PILC_SEQ;
          next_s.cnt   = PILC_ACCEPT_LOAD;
        end
      end
      PILC_SEQ: begin
        if (s.cnt == 4'h0) begin
          next_s.state = PILC_DONE;
          next_s.vload = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      PILC_DONE: begin
        next_s.state = PILC_IDLE;
      end
      default: begin
        next_s.state = PILC_IDLE;
      end
    endcase

    // write channels, address and data taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_have = 1'b1;
      next_s.aw_idx  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.wready = 1'b0;
      next_s.w_have = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wlane0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      case (s.aw_idx)
        PILC_IDX_LOW_ENABLE, PILC_IDX_HIGH_ENABLE, PILC_IDX_EXT_ENABLE,
        PILC_IDX_LOW_LATCH, PILC_IDX_HIGH_LATCH, PILC_IDX_EXT_LATCH: begin
          next_s.bresp = PILC_RESP_OKAY;
        end
        default: begin
          next_s.bresp = PILC_RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    // read channel
    if (rd_fire) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = PILC_RESP_OKAY;
      next_s.rdata   = '0;
      case (rd_idx)
        PILC_IDX_LOW_ENABLE:  next_s.rdata[7:0] = {s.en[7:4], 3'h0, s.en[0]};
        PILC_IDX_HIGH_ENABLE: next_s.rdata[7:0] = s.en[15:8];
        PILC_IDX_EXT_ENABLE:  next_s.rdata[7:0] = s.en[23:16];
        PILC_IDX_LOW_LATCH:   next_s.rdata[7:0] = s.lat[7:0];
        PILC_IDX_HIGH_LATCH:  next_s.rdata[7:0] = s.lat[15:8];
        PILC_IDX_EXT_LATCH:   next_s.rdata[7:0] = s.lat[23:16];
        default:              next_s.rresp      = PILC_RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= PILC_RST;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready      = s.awready;
  assign s_axi_wready       = s.wready;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = s.arready;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign int_request        = s.req;
  assign int_nmi            = s.nmi;
  assign int_source         = s.sel;
  assign int_vector         = s.vec;
  assign vector_load        = s.vload;
  assign stacked_master_enable = s.stacked_master;
  assign master_enable_flag    = s.en[PILC_MASTER_BIT];

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_LATCH_SET: assert property (request_event[9] |=> s.lat[9])
    else $error("request event did not set its latch");

  // any latched source taken by the core loses its latch unless a new event arrives
  AST_ACCEPT_CLEAR: assert property (
    accept && s.sel >= PILC_SRC_ATRAP && !request_event[s.sel] |=> !s.lat[$past(s.sel)])
    else $error("accepted latch not cleared");

  AST_RESET_STATE: assert property (
    $rose(aresetn) |-> s.lat == 24'h000000 && s.en == 24'h000000)
    else $error("latches or enables not cleared by reset");

  AST_NO_TRAP_LATCH: assert property (s.lat[1:0] == 2'h0)
    else $error("trap sources hold a latch");

  AST_SW_NO_SET: assert property (
    !s.lat[6] && !request_event[6] |=> !s.lat[6])
    else $error("latch set without an event");

  AST_MASK_GATE: assert property (
    int_request && !int_nmi |-> $past(s.en[0]) && $past(s.en[next_s.sel]))
    else $error("maskable request presented without enables");

  AST_PIN0_GATE: assert property (
    int_request && int_source == 5'h04 |-> $past(pin_zero_enable))
    else $error("pin zero presented without pin enable");

  AST_NMI_FREE: assert property (
    s.state == PILC_IDLE && s.lat[2] && !accept |=> int_request && int_nmi)
    else $error("non-maskable request not presented");

  AST_STACK_MASTER: assert property (
    accept |=> !master_enable_flag && stacked_master_enable == $past(s.en[0]))
    else $error("master enable not stacked and cleared");

  AST_RETURN_MASTER: assert property (
    (maskable_return || nonmaskable_return) && !accept
    |=> master_enable_flag == $past(return_master_enable))
    else $error("return did not reload master enable");

  // vector load stays low for eight cycles after the accept edge, then pulses
  AST_SEQ_LEN: assert property (
    accept |=> !vector_load [*8] ##1 vector_load)
    else $error("acceptance sequence length wrong");

  COV_NMI_ACCEPT:  cover property (accept && int_nmi);
  COV_MASK_ACCEPT: cover property (accept && !int_nmi);
  COV_RETURN:      cover property (maskable_return ##[1:20] int_request);
  COV_BUS_CLEAR:   cover property (wr_fire && |bus_clr);

endmodule // pilc_top

// ---- tb/pilc_cpu_model.sv ----
// cpu core model: takes presented interrupts and returns the stacked master enable
`timescale 1ns/100ps

module pilc_cpu_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench control: accept on, cycles to wait
  input  wire logic       take_en,
  input  wire logic [3:0] take_dly,
  // controller side
  input  wire logic       int_request,
  input  wire logic       vector_load,
  input  wire logic       stacked_master_enable,
  output logic            cpu_accept,
  output logic            return_master_enable
);
  logic [3:0] wait_cnt;

  initial begin
    cpu_accept = 1'b0;
    return_master_enable = 1'b0;
    wait_cnt   = 4'h0;
  end

  always @(posedge aclk) begin
    cpu_accept <= 1'b0;
    if (!aresetn) begin
      wait_cnt   <= 4'h0;
      return_master_enable <= 1'b0;
    end else begin
      if (take_en && int_request && !cpu_accept) begin
        // slow core waits take_dly cycles first
        if (wait_cnt >= take_dly) begin
          cpu_accept <= 1'b1;
          wait_cnt   <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
      // stack slot given back with a return
      if (vector_load) begin
        return_master_enable <= stacked_master_enable;
      end
    end
  end
endmodule // pilc_cpu_model

// ---- tb/prioritized_interrupt_latch_controller_tb.sv ----
// self-checking bench of the prioritized interrupt latch controller
`timescale 1ns/100ps

module prioritized_interrupt_latch_controller_tb;
  import pilc_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] resp;
  } pilc_row_t;

  logic        aclk, aresetn, take_en, cpu_accept, return_master_enable, pin_zero_enable;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, software_trap, undefined_opcode_trap;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [23:2] request_event;
  logic [3:0]  ctl, take_dly;
  logic        int_request, int_nmi, vector_load, stacked_master_enable, master_enable_flag;
  logic [4:0]  int_source;
  logic [15:0] int_vector;
  logic [15:0] nvec [4] = '{16'hfffc, 16'hfffc, 16'hfffa, 16'hfff8};
  int          errors, tests_run, n;
  pilc_row_t   rows [16] = '{
    '{1'b0, 8'h2c, 8'h00, 8'h00, 2'h0}, '{1'b0, 8'h2e, 8'h00, 8'h00, 2'h0},
    '{1'b0, 8'h3a, 8'h00, 8'h00, 2'h0}, '{1'b0, 8'h3b, 8'h00, 8'h00, 2'h0},
    '{1'b0, 8'h3c, 8'h00, 8'h00, 2'h0}, '{1'b0, 8'h3d, 8'h00, 8'h00, 2'h0},
    '{1'b1, 8'h2c, 8'hff, 8'hff, 2'h0}, '{1'b1, 8'h3a, 8'hff, 8'hf1, 2'h0},
    '{1'b1, 8'h3b, 8'ha5, 8'ha5, 2'h0}, '{1'b1, 8'h3c, 8'hff, 8'h00, 2'h0},
    '{1'b1, 8'h3d, 8'hff, 8'h00, 2'h0}, '{1'b1, 8'h2e, 8'hff, 8'h00, 2'h0},
    '{1'b1, 8'h30, 8'hff, 8'h00, 2'h2}, '{1'b1, 8'h3a, 8'h20, 8'h20, 2'h0},
    '{1'b1, 8'h3b, 8'h02, 8'h02, 2'h0}, '{1'b1, 8'h2c, 8'h00, 8'h00, 2'h0}};

  pilc_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .request_event, .software_trap, .undefined_opcode_trap,
    .pin_zero_enable, .cpu_accept, .maskable_return(ctl[2]),
    .nonmaskable_return(ctl[3]), .return_master_enable, .enable_all_instruction(ctl[0]),
    .disable_all_instruction(ctl[1]), .int_request, .int_nmi, .int_source,
    .int_vector, .vector_load, .stacked_master_enable, .master_enable_flag);

  pilc_cpu_model cpu (.aclk, .aresetn, .take_en, .take_dly, .int_request,
    .vector_load, .stacked_master_enable, .cpu_accept, .return_master_enable);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wchk(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr  <= {22'h0, idx, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 40);
    s_axi_bready <= 1'b0;
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr  <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 40);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e});
    chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge aclk);
    ctl <= v;
    @(posedge aclk);
    ctl <= 4'h0;
  endtask

  task automatic ev(input logic [23:2] m);
    @(posedge aclk);
    request_event <= m;
    @(posedge aclk);
    request_event <= '0;
  endtask

  task automatic pchk(input logic [4:0] s, input logic [15:0] v, input logic m);
    int k;
    k = 0;
    while (int_request !== 1'b1 && k < 20) begin
      @(posedge aclk);
      k++;
    end
    chk({9'h0, int_request, int_nmi, int_source, int_vector}, {9'h0, 1'b1, m, s, v});
  endtask

  // core accepts; traps drop once taken; n counts edges to vector load
  task automatic acc(output int n);
    int k;
    k = 0;
    n = 0;
    @(posedge aclk);
    take_en <= 1'b1;
    while (cpu_accept !== 1'b1 && k < 40) begin
      @(posedge aclk);
      k++;
    end
    take_en               <= 1'b0;
    software_trap         <= 1'b0;
    undefined_opcode_trap <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (vector_load !== 1'b1 && n < 20);
    chk({31'h0, vector_load}, 32'h1);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    {aresetn, take_en, pin_zero_enable, software_trap, undefined_opcode_trap} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    request_event = '0;
    ctl           = 4'h0;
    take_dly      = 4'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wchk(rows[i].idx, rows[i].wd, rows[i].resp);
      rchk(rows[i].idx, rows[i].rd, rows[i].resp);
    end
    $display("register table done");
    ev(22'h000088);
    repeat (3) @(posedge aclk);
    chk({31'h0, int_request}, 32'h0);
    rchk(8'h3c, 8'h20, 2'h0);
    rchk(8'h3d, 8'h02, 2'h0);
    pulse(4'h1);
    pchk(5'h05, 16'hfff4, 1'b0);
    take_dly <= 4'h3;
    acc(n);
    chk(32'(n), 32'h9);
    chk({30'h0, master_enable_flag, stacked_master_enable}, 32'h1);
    rchk(8'h3c, 8'h00, 2'h0);
    chk({31'h0, int_request}, 32'h0);
    pulse(4'h4);
    pchk(5'h09, 16'hffec, 1'b0);
    pulse(4'h2);
    wchk(8'h3d, 8'hfd, 2'h0);
    rchk(8'h3d, 8'h00, 2'h0);
    chk({31'h0, int_request}, 32'h0);
    $display("maskable acceptance done");
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      case (i)
        0: software_trap <= 1'b1;
        1: undefined_opcode_trap <= 1'b1;
        default: request_event[i] <= 1'b1;
      endcase
      @(posedge aclk);
      request_event <= '0;
      rchk(8'h3c, 8'(1 << i) & 8'h0c, 2'h0);
      pchk(5'(i), nvec[i], 1'b1);
      acc(n);
      pulse(4'h8);
      chk({30'h0, master_enable_flag, stacked_master_enable}, 32'h0);
      rchk(8'h3c, 8'h00, 2'h0);
    end
    $display("non-maskable sources done");
    wchk(8'h3a, 8'h10, 2'h0);
    ev(22'h000004);
    pulse(4'h1);
    repeat (3) @(posedge aclk);
    chk({31'h0, int_request}, 32'h0);
    pin_zero_enable <= 1'b1;
    pchk(5'h04, 16'hfff6, 1'b0);
    pulse(4'h2);
    wchk(8'h3c, 8'hef, 2'h0);
    rchk(8'h3c, 8'h00, 2'h0);
    $display("pin zero gate done");
    wchk(8'h2c, 8'h80, 2'h0);
    pulse(4'h1);
    ev(22'h200000);
    rchk(8'h2e, 8'h80, 2'h0);
    pchk(5'h17, 16'hffb0, 1'b0);
    take_dly <= 4'h0;
    acc(n);
    rchk(8'h2e, 8'h00, 2'h0);
    $display("last source done");
    ev(22'h200000);
    rchk(8'h2e, 8'h80, 2'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h2e, 8'h00, 2'h0);
    rchk(8'h2c, 8'h00, 2'h0);
    chk({31'h0, master_enable_flag}, 32'h0);
    $display("mid-run reset done");
    stop_test();
  end
endmodule // prioritized_interrupt_latch_controller_tb
